// [verilog/mlc_top.sv]
// memory layout configuration register with decoded memory controls
`timescale 1ns/1ns
`include "mlc_defines.svh"
module mlc_top (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [`MLC_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic prom_width_pin_i,
  input wire logic prom_write_strobe_n_i,
  input wire logic parity_check_inhibit_n_i,
  input wire logic [7:0] base_cs_i,
  output logic [9:0] memory_chip_select_o,
  output logic ram_parity_check_o,
  output logic ram_edac_check_o,
  output logic exchange_parity_check_o,
  output logic exchange_edac_check_o,
  output logic exchange_present_o,
  output logic prom_write_allow_o,
  output logic prom_wide_o,
  output logic [4:0] ram_log2_kb_o,
  output logic [4:0] prom_log2_kb_o,
  output logic [4:0] exchange_log2_kb_o
);
  import mlc_pkg::*;

  mlc_state_s s_q, s_d;
  logic strap_pend_q;

  // ============================================================
  // chip select substitution
  function automatic logic [9:0] spare_map(input logic [31:0] c,
                                           input logic [7:0] b);
    logic [9:0] o;
    logic [2:0] t0;
    logic [2:0] t1;
    o = {2'b00, b};
    t0 = c[`MLC_SB0_LSB+:3];
    t1 = c[`MLC_SB1_LSB+:3];
    if (c[`MLC_SB0_SEL] && b[t0]) begin
      o[t0] = 1'b0;
      o[8] = 1'b1;
    end
    // second spare only acts when its code differs from the first spare's code
    if (c[`MLC_SB1_SEL] && (t1 != t0)) begin
      // code 111 aliases select 0, codes 0..6 map straight
      if (t1 == 3'h7) begin
        t1 = 3'h0;
      end
      if (b[t1]) begin
        o[t1] = 1'b0;
        o[9] = 1'b1;
      end
    end
    return o;
  endfunction

  function automatic logic [4:0] size_log2(input logic [2:0] code,
                                           input logic [4:0] base);
    return base + {2'b00, code};
  endfunction

  // ============================================================
  // next state
  always_comb begin
    logic [31:0] wmask;
    logic [31:0] wnew;
    logic par_ok;
    wmask = '0;
    wnew = '0;
    s_d = s_q;
    par_ok = parity_check_inhibit_n_i;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8+:8] = {8{avs_byteenable_i[i]}};
    end
    wmask = wmask & `MLC_WR_MASK;
    case (s_q.state)
      MLC_IDLE: begin
        if (avs_write_i || avs_read_i) begin
          s_d.state = MLC_ACK;
          // load read data now so it stands while waitrequest is low
          if (avs_address_i == `MLC_CFG_ADDR) begin
            s_d.rdata = s_q.cfg;
          end else begin
            s_d.rdata = 32'h0000_0000;
          end
        end
      end
      MLC_ACK: begin
        // write lands at the edge where the master sees waitrequest low
        if (avs_write_i && avs_address_i == `MLC_CFG_ADDR) begin
          wnew = (s_q.cfg & ~wmask) | (avs_writedata_i & wmask);
          s_d.cfg = wnew;
        end
        s_d.state = MLC_DONE;
      end
      MLC_DONE: begin
        s_d.state = MLC_IDLE;
      end
      default: begin
        s_d.state = MLC_IDLE;
      end
    endcase
    // strap capture one cycle after reset release
    if (strap_pend_q) begin
      s_d.cfg[`MLC_P8] = prom_width_pin_i;
    end
    s_d.cs_out = spare_map(s_q.cfg, base_cs_i);
    s_d.ram_par = par_ok && (s_q.cfg[`MLC_RPA] ||
                             s_q.cfg[`MLC_REC]);
    s_d.ram_edac = s_q.cfg[`MLC_REC];
    s_d.exc_par = par_ok && (s_q.cfg[`MLC_EPA] ||
                             s_q.cfg[`MLC_EEC]);
    s_d.exc_edac = s_q.cfg[`MLC_EEC];
    s_d.exc_present = s_q.cfg[`MLC_EEX];
    s_d.prom_wr_ok = s_q.cfg[`MLC_PWR] &&
                     !prom_write_strobe_n_i;
    s_d.prom_wide = s_q.cfg[`MLC_P8];
    s_d.ram_log2_kb = size_log2(s_q.cfg[`MLC_RAM_SIZE_FIELD_LSB+:3],
                                `MLC_RAM_KB_BASE);
    s_d.prom_log2_kb = size_log2(s_q.cfg[`MLC_PROM_SIZE_FIELD_LSB+:3],
                                 `MLC_PROM_KB_BASE);
    s_d.exc_log2_kb = size_log2(s_q.cfg[`MLC_EXCHANGE_SIZE_FIELD_LSB+:3],
                                `MLC_EXC_KB_BASE);
  end

  // ============================================================
  // registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '{state: MLC_IDLE, cfg: `MLC_RESET_VAL,
               ram_log2_kb: `MLC_RAM_KB_BASE,
               prom_log2_kb: `MLC_PROM_KB_BASE,
               exc_log2_kb: `MLC_EXC_KB_BASE, default: '0};
      strap_pend_q <= 1'b1;
    end else begin
      s_q <= s_d;
      strap_pend_q <= 1'b0;
    end
  end

  assign avs_waitrequest_o = ~s_q.state[1];
  assign avs_readdata_o = s_q.rdata;
  assign memory_chip_select_o = s_q.cs_out;
  assign ram_parity_check_o = s_q.ram_par;
  assign ram_edac_check_o = s_q.ram_edac;
  assign exchange_parity_check_o = s_q.exc_par;
  assign exchange_edac_check_o = s_q.exc_edac;
  assign exchange_present_o = s_q.exc_present;
  assign prom_write_allow_o = s_q.prom_wr_ok;
  assign prom_wide_o = s_q.prom_wide;
  assign ram_log2_kb_o = s_q.ram_log2_kb;
  assign prom_log2_kb_o = s_q.prom_log2_kb;
  assign exchange_log2_kb_o = s_q.exc_log2_kb;

  // ============================================================
  // assertions
  chk_p8_write_ignored: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) !$past(strap_pend_q) |->
    $stable(s_q.cfg[`MLC_P8])) else $error("width flag changed");
  chk_p8_strap_load: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) strap_pend_q |=>
    s_q.cfg[`MLC_P8] == $past(prom_width_pin_i))
    else $error("width strap not loaded");
  chk_ram_parity_on: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) (s_q.cfg[`MLC_RPA] || s_q.cfg[`MLC_REC]) &&
    parity_check_inhibit_n_i |=> ram_parity_check_o)
    else $error("ram parity not enabled");
  chk_ram_edac_par: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) ram_edac_check_o && $past(parity_check_inhibit_n_i)
    |-> ram_parity_check_o) else $error("edac without parity");
  chk_exc_edac_par: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) s_q.cfg[`MLC_EEC] && parity_check_inhibit_n_i
    |=> exchange_parity_check_o && exchange_edac_check_o)
    else $error("exchange edac without parity");
  chk_exc_parity_on: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) s_q.cfg[`MLC_EPA] && parity_check_inhibit_n_i
    |=> exchange_parity_check_o)
    else $error("exchange parity not enabled");
  chk_inhibit_parity: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) !parity_check_inhibit_n_i |=>
    !ram_parity_check_o && !exchange_parity_check_o)
    else $error("parity checked while inhibited");
  chk_prom_write_gate: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) prom_write_allow_o |->
    $past(s_q.cfg[`MLC_PWR]) && !$past(prom_write_strobe_n_i))
    else $error("prom write allowed wrongly");
  chk_spare1_same: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) s_q.cfg[`MLC_SB1_LSB+:3] == s_q.cfg[`MLC_SB0_LSB+:3]
    |=> !memory_chip_select_o[9]) else $error("spare1 acted");
  chk_spare1_swap: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) memory_chip_select_o[9] |->
    $past(s_q.cfg[`MLC_SB1_SEL])) else $error("spare1 unselected");
  chk_ram_size: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) 1'b1 |=> ram_log2_kb_o ==
    5'd8 + {2'b00, $past(s_q.cfg[12:10])}) else $error("ram size");
  cov_write: cover property (@(posedge clk_sys_i) avs_write_i &&
    !avs_waitrequest_o);
  cov_read: cover property (@(posedge clk_sys_i) avs_read_i &&
    !avs_waitrequest_o);
  cov_spare1: cover property (@(posedge clk_sys_i) memory_chip_select_o[9]);
  cov_inhibit: cover property (@(posedge clk_sys_i)
    s_q.cfg[`MLC_REC] && !parity_check_inhibit_n_i);
  cov_strap_high: cover property (@(posedge clk_sys_i)
    strap_pend_q && prom_width_pin_i);

  // ============================================================
  // decode and bus checks
  chk_prom_wide_out: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) 1'b1 |=>
    prom_wide_o == $past(s_q.cfg[`MLC_P8]))
    else $error("prom width output wrong");
  chk_prom_size: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) 1'b1 |=> prom_log2_kb_o ==
    `MLC_PROM_KB_BASE + {2'b00, $past(s_q.cfg[`MLC_PROM_SIZE_FIELD_LSB+:3])})
    else $error("prom size");
  chk_exc_size: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) 1'b1 |=> exchange_log2_kb_o ==
    `MLC_EXC_KB_BASE + {2'b00, $past(s_q.cfg[`MLC_EXCHANGE_SIZE_FIELD_LSB+:3])})
    else $error("exchange size");
  chk_exc_present: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) 1'b1 |=>
    exchange_present_o == $past(s_q.cfg[`MLC_EEX]))
    else $error("exchange presence wrong");
  chk_ram_edac_out: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) 1'b1 |=>
    ram_edac_check_o == $past(s_q.cfg[`MLC_REC]))
    else $error("ram edac output wrong");
  chk_exc_edac_out: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) 1'b1 |=>
    exchange_edac_check_o == $past(s_q.cfg[`MLC_EEC]))
    else $error("exchange edac output wrong");
  chk_reserved_zero: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) (s_q.cfg & `MLC_RSVD_MASK) == 32'h0000_0000)
    else $error("reserved bit set");
  chk_prom_write_off: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) !s_q.cfg[`MLC_PWR] |=> !prom_write_allow_o)
    else $error("prom write with function off");
  chk_wait_one_cycle: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  chk_rdata_hold: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) !(s_q.state == MLC_IDLE &&
    (avs_read_i || avs_write_i)) |=> $stable(avs_readdata_o))
    else $error("read data moved");
  chk_read_cfg: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) s_q.state == MLC_IDLE && avs_read_i &&
    avs_address_i == `MLC_CFG_ADDR |=>
    avs_readdata_o == $past(s_q.cfg)) else $error("read data wrong");
  chk_read_unmapped: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) s_q.state == MLC_IDLE && avs_read_i &&
    avs_address_i != `MLC_CFG_ADDR |=>
    avs_readdata_o == 32'h0000_0000) else $error("unmapped read");
  chk_write_lands: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) s_q.state == MLC_ACK && avs_write_i &&
    avs_address_i == `MLC_CFG_ADDR && avs_byteenable_i[1] |=>
    s_q.cfg[`MLC_RPA] == $past(avs_writedata_i[`MLC_RPA]))
    else $error("write did not land");
  // without spares the base selects pass through one cycle late
  chk_cs_passthru: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) !s_q.cfg[`MLC_SB0_SEL] && !s_q.cfg[`MLC_SB1_SEL]
    |=> memory_chip_select_o == {2'b00, $past(base_cs_i)})
    else $error("selects not passed through");
  // code 111 of the second spare lands on select 0
  chk_spare1_alias: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) s_q.cfg[`MLC_SB1_SEL] &&
    s_q.cfg[`MLC_SB1_LSB+:3] == 3'h7 &&
    s_q.cfg[`MLC_SB0_LSB+:3] != 3'h7 && base_cs_i[0] |=>
    !memory_chip_select_o[0] && memory_chip_select_o[9])
    else $error("spare1 code 7 not decoded");
  // one check per straight-mapped code 2..6 of the second spare
  for (genvar k = 2; k < 7; k++) begin : g_spare1_code
    localparam logic [2:0] spare_code = 3'(k);
    chk_spare1_code: assert property (@(posedge clk_sys_i)
      disable iff (rst_i) s_q.cfg[`MLC_SB1_SEL] &&
      s_q.cfg[`MLC_SB1_LSB+:3] == spare_code &&
      s_q.cfg[`MLC_SB0_LSB+:3] != spare_code && base_cs_i[k] |=>
      !memory_chip_select_o[k] && memory_chip_select_o[9])
      else $error("spare1 code not decoded");
  end
endmodule

// [verilog/mlc_defines.svh]
// constants for the memory layout configuration register block
`ifndef MLC_DEFINES_SVH
`define MLC_DEFINES_SVH
// ============================================================
// ============================================================
`define MLC_ADDR_W 4
`define MLC_CFG_ADDR 4'h0
`define MLC_RESET_VAL 32'h0001_0000
`define MLC_WR_MASK 32'h3F1D_7FFF
`define MLC_RSVD_MASK 32'hC0E0_8000
`define MLC_SB0_SEL 2
`define MLC_SB0_LSB 3
`define MLC_SB1_SEL 6
`define MLC_SB1_LSB 7
`define MLC_RAM_SIZE_FIELD_LSB 10
`define MLC_RPA 13
`define MLC_REC 14
`define MLC_PWR 16
`define MLC_P8 17
`define MLC_PROM_SIZE_FIELD_LSB 18
`define MLC_EXCHANGE_SIZE_FIELD_LSB 24
`define MLC_EPA 27
`define MLC_EEC 28
`define MLC_EEX 29
`define MLC_RAM_KB_BASE 5'd8
`define MLC_PROM_KB_BASE 5'd7
`define MLC_EXC_KB_BASE 5'd2
`endif

// [verilog/mlc_pkg.sv]
// types for the memory layout configuration register block
package mlc_pkg;
  typedef enum logic [2:0] {
    MLC_IDLE = 3'b001,
    MLC_ACK = 3'b010,
    MLC_DONE = 3'b100
  } mlc_state_e;
  typedef struct packed {
    mlc_state_e state;
    logic [31:0] cfg;
    logic [31:0] rdata;
    logic [9:0] cs_out;
    logic ram_par;
    logic ram_edac;
    logic exc_par;
    logic exc_edac;
    logic exc_present;
    logic prom_wr_ok;
    logic prom_wide;
    logic [4:0] ram_log2_kb;
    logic [4:0] prom_log2_kb;
    logic [4:0] exc_log2_kb;
  } mlc_state_s;
endpackage

// [bench/mlc_mem_model.sv]
// far-side memory model: strap pin and external strobe levels
`timescale 1ns/1ns
module mlc_mem_model (
  input wire logic [9:0] cs_i,
  input wire logic strap_i,
  input wire logic strobe_i,
  input wire logic inhibit_i,
  output logic prom_width_pin_o,
  output logic prom_write_strobe_n_o,
  output logic parity_check_inhibit_n_o
);
  // ============================================================
  // board levels
  // strap is static on the board; the bench may move it only to probe
  assign prom_width_pin_o = strap_i;
  assign prom_write_strobe_n_o = !strobe_i;
  assign parity_check_inhibit_n_o = !inhibit_i;
endmodule

// [bench/tb.sv]
// self-checking bench for the memory layout configuration register
`timescale 1ns/1ns
`include "mlc_defines.svh"
module tb;
  logic clk_sys_i = 0, rst_i = 1, rd = 0, wr = 0, strap = 0;
  logic strb = 0, inh = 0, wq, pin, sn, ih;
  logic rp, re, xp, xe, xq, pw, pwide;
  logic [3:0] addr = 0, be = 0;
  logic [7:0] base = 0;
  logic [9:0] cs;
  logic [4:0] rl, pl, xl;
  logic [31:0] wd = 0, rdata, m, r, d, t;
  int seed = 94, miscompares = 0, samples_checked = 0, i;
  always #50 clk_sys_i = ~clk_sys_i;
  mlc_mem_model u_mlc_mem_model (.cs_i(cs), .strap_i(strap),
    .strobe_i(strb), .inhibit_i(inh), .prom_width_pin_o(pin),
    .prom_write_strobe_n_o(sn), .parity_check_inhibit_n_o(ih));
  mlc_top u_mlc_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wq), .prom_width_pin_i(pin),
    .prom_write_strobe_n_i(sn), .parity_check_inhibit_n_i(ih),
    .base_cs_i(base), .memory_chip_select_o(cs), .ram_parity_check_o(rp),
    .ram_edac_check_o(re), .exchange_parity_check_o(xp),
    .exchange_edac_check_o(xe), .exchange_present_o(xq),
    .prom_write_allow_o(pw), .prom_wide_o(pwide), .ram_log2_kb_o(rl),
    .prom_log2_kb_o(pl), .exchange_log2_kb_o(xl));
  // ============================================================
  // reporting
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // ============================================================
  // model and bus
  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] v, input logic [3:0] b);
    logic [31:0] k;
    k = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & `MLC_WR_MASK;
    return (o & ~k) | (v & k);
  endfunction
  task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] v, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    addr <= a;
    wd <= v;
    be <= b;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wq !== 1'b0 && n < 20);
    if (wq !== 1'b0) begin
      miscompares++;
      tally_and_finish();
    end
    r = rdata;
    if (w && a == `MLC_CFG_ADDR) m = merge(m, v, b);
    rd <= 0;
    wr <= 0;
    @(posedge clk_sys_i);
  endtask
  task automatic do_reset(input logic s);
    strap <= s;
    rst_i <= 1;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 0;
    m = `MLC_RESET_VAL | ({31'h0, s} << `MLC_P8);
  endtask
  task automatic check_ctl;
    logic [9:0] c;
    logic [2:0] t0, t1;
    t0 = m[5:3];
    t1 = (m[9:7] == 3'h7) ? 3'h0 : m[9:7];
    c = {2'b00, base};
    if (m[2] && base[t0]) begin
      c[t0] = 0;
      c[8] = 1;
    end
    if (m[6] && m[9:7] != m[5:3] && base[t1]) begin
      c[t1] = 0;
      c[9] = 1;
    end
    cmp_word({cs, rp, re, xp, xe, xq, pw, pwide, rl, pl, xl},
      {c, (m[13] | m[14]) & !inh, m[14], (m[27] | m[28]) & !inh, m[28],
      m[29], m[16] & strb, m[17], 5'h8 + {2'h0, m[12:10]},
      5'h7 + {2'h0, m[20:18]}, 5'h2 + {2'h0, m[26:24]}});
  endtask
  // ============================================================
  // sequence
  initial begin
    for (i = 0; i < 2; i++) begin
      do_reset(i == 0);
      bus(0, `MLC_CFG_ADDR, 32'h0, 4'hF);
      cmp_word(r, m);
      strap <= (i != 0);
      bus(1, `MLC_CFG_ADDR, 32'hFFFF_FFFF, 4'hF);
      bus(0, `MLC_CFG_ADDR, 32'h0, 4'hF);
      cmp_word(r, m);
      $display("test reset %0d done", i);
    end
    for (i = 0; i < 48; i++) begin
      d = $random(seed);
      t = $random(seed);
      if (merge(m, d, t[3:0]) ==? 32'b????_????_????_????_????_??11_1000_0???) begin
        t[1] = 1;
        d[9] = 0;
      end
      bus(1, (i % 8 == 7) ? 4'h7 : `MLC_CFG_ADDR, d, t[3:0]);
      @(posedge clk_sys_i);
      base <= t[15:8];
      strb <= t[16];
      inh <= t[17];
      repeat (3) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      check_ctl();
      bus(0, (i % 8 == 7) ? 4'h7 : `MLC_CFG_ADDR, 32'h0, 4'hF);
      cmp_word(r, (i % 8 == 7) ? 32'h0 : m);
    end
    $display("test random done");
    tally_and_finish();
  end
endmodule
